// [hw/acm_defs.svh]
// constants of the audio clock mode controller: offsets, fields, resets, timing
// assumes a single 125 MHz bus clock and 32-bit AXI4-Lite register access
//
// Notes on behaviour
// - pll_power on: clocks come from the PLL
// - ref codes 0/2/3: frame, bit 32fs, 64fs
// - ref codes 4-7,9,12,13 use master_clk_in; others unavailable
// - clocks invalid until lock; lock time per reference
// - master_clk_in reference: twelve fs_select rate codes
// - frame/bit reference: upper fs_select bits choose range
// - pll master before lock: bit/frame low
// - after lock, normal clocks after one sample
// - pll_power cleared in master: bit/frame restart from master_clk_in
// - later unlock: bit/frame may be invalid
// - pll slave: mclk_out low with bit/frame ref; with mclk ref invalid, then divided when locked
// - mclk_out_div picks 256/128/64/32fs when enabled
// - master: bit clock 32/64fs, frame 1fs
// - pll_power off: run from master_clk_in
// - external: low fs_select bits give mclk ratio
// - external master: derive bit/frame from master_clk_in
// - mclk_out_div applies in external mode and in pll mode once locked (scrambled before lock); pll slave with bit/frame ref keeps mclk_out low
// - master_slave_select 1 master, reset slave
// - dac powers up only once master_clk_in toggles
`ifndef ACM_DEFS_SVH
`define ACM_DEFS_SVH

`define ACM_OFF_CTRL 12'h000
`define ACM_OFF_STATUS 12'h004
`define ACM_CTRL_RST 32'h0000_0000
`define ACM_CTRL_MASK 32'h0007_FFF3
`define ACM_RESP_OKAY 2'b00
`define ACM_RESP_SLVERR 2'b10

`define ACM_CLK_HZ 125000000
`define ACM_MS_PER_S 1000
`define ACM_LOCK_FRAME_MS 160
`define ACM_LOCK_BIT_MS 4
`define ACM_LOCK_MCLK_MS 40
`define ACM_LOCK_MCLK_SLOW_MS 200
`define ACM_LOCK_W 25

// generator runs at 512fs; tap positions of the divided clocks
`define ACM_BASE_MULT 512
`define ACM_GEN_W 9
`define ACM_TAP_256FS 0
`define ACM_TAP_128FS 1
`define ACM_TAP_64FS 2
`define ACM_TAP_32FS 3
`define ACM_TAP_1FS 8
`define ACM_TICK_W 16
`define ACM_TICK_CYC(f) (`ACM_CLK_HZ / (`ACM_BASE_MULT * (f)))
`define ACM_SCRAMBLE_BIT 3

`endif

// [hw/acm_pkg.sv]
// types of the audio clock mode controller
// assumes acm_defs.svh supplies all numeric constants
package acm_pkg;

  typedef struct packed {
    logic [12:0] rsvd_hi;
    logic spk_dac_path;
    logic hp_dac_path;
    logic dac_power;
    logic bitclk_out_rate;
    logic [1:0] mclk_out_div;
    logic mclk_out_enable;
    logic [3:0] fs_select;
    logic [3:0] pll_ref_select;
    logic [1:0] rsvd_lo;
    logic master_slave_select;
    logic pll_power;
  } acm_ctrl_t;

  typedef enum logic [2:0] {
    ACM_ST_BYPASS,
    ACM_ST_PWRUP,
    ACM_ST_SETTLE,
    ACM_ST_LOCKED,
    ACM_ST_RELOCK
  } acm_state_t;

  typedef enum logic [2:0] {
    ACM_REF_FRAME,
    ACM_REF_BIT,
    ACM_REF_MCLK,
    ACM_REF_MCLK_SLOW,
    ACM_REF_NA
  } acm_ref_t;

  typedef struct packed {
    logic [22:0] rsvd;
    logic mute_advised;
    logic fs_ok;
    logic ref_ok;
    logic dac_active;
    logic clocks_valid;
    logic locked;
    acm_state_t state;
  } acm_status_t;

endpackage

// [hw/acm_tick_div.sv]
// programmable divider: one-cycle tick every period cycles of aclk
// assumes period is at least one and held stable while enabled
`timescale 1ns/1ps
module acm_tick_div #(
  parameter int W = 16
) (
  input wire logic aclk, // bus clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic en, // run the divider
  input wire logic clr, // restart the count
  input wire logic [W-1:0] period, // cycles between ticks
  output logic tick_r // one-cycle tick
);

  logic [W-1:0] cnt_r;

  if (W < 2) begin : g_chk
    $error("acm_tick_div: W must be at least 2");
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (clr || !en) begin
      cnt_r <= period - W'(1);
      tick_r <= 1'b0;
    end else if (cnt_r == '0) begin
      cnt_r <= period - W'(1);
      tick_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r - W'(1);
      tick_r <= 1'b0;
    end
  end

endmodule

// [hw/acm_top.sv]
// audio clock mode controller: pll/external and master/slave clock selection
// assumes audio pins are synchronous to aclk; registers over AXI4-Lite
`timescale 1ns/1ps
`include "acm_defs.svh"
module acm_top import acm_pkg::*; #(
  parameter int ADDR_W = 12,
  parameter int LOCK_FRAME_CYC = `ACM_LOCK_FRAME_MS * (`ACM_CLK_HZ / `ACM_MS_PER_S),
  parameter int LOCK_BIT_CYC = `ACM_LOCK_BIT_MS * (`ACM_CLK_HZ / `ACM_MS_PER_S),
  parameter int LOCK_MCLK_CYC = `ACM_LOCK_MCLK_MS * (`ACM_CLK_HZ / `ACM_MS_PER_S),
  parameter int LOCK_MCLK_SLOW_CYC = `ACM_LOCK_MCLK_SLOW_MS * (`ACM_CLK_HZ / `ACM_MS_PER_S)
) (
  input wire logic aclk, // bus and logic clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic [2:0] s_axi_awprot, // unused protection
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic [2:0] s_axi_arprot, // unused protection
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic master_clk_in, // master clock pin
  input wire logic bit_clock_in, // bit clock pin level
  input wire logic frame_clock_in, // frame clock pin level
  output logic bit_clock_out, // bit clock drive value
  output logic bit_clock_oe, // bit clock drive enable
  output logic frame_clock_out, // frame clock drive value
  output logic frame_clock_oe, // frame clock drive enable
  output logic mclk_out, // master clock output pin
  output logic dac_run, // dac out of power-down
  output logic hp_path_en, // headphone dac path
  output logic spk_path_en // speaker dac path
);

  if (ADDR_W < 3 || LOCK_FRAME_CYC < 1 || LOCK_BIT_CYC < 1 || LOCK_MCLK_CYC < 1 ||
      LOCK_MCLK_SLOW_CYC < 1) begin : g_chk_min
    $error("acm_top: address width or lock counts too small");
  end
  if (LOCK_FRAME_CYC >= (1 << `ACM_LOCK_W) || LOCK_MCLK_SLOW_CYC >= (1 << `ACM_LOCK_W) ||
      LOCK_MCLK_CYC >= (1 << `ACM_LOCK_W) || LOCK_BIT_CYC >= (1 << `ACM_LOCK_W)) begin : g_chk_max
    $error("acm_top: lock counts exceed the lock counter");
  end

  function automatic acm_ref_t ref_decode(input logic [3:0] code);
    case (code)
      4'h0: ref_decode = ACM_REF_FRAME;
      4'h2, 4'h3: ref_decode = ACM_REF_BIT;
      4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hD: ref_decode = ACM_REF_MCLK;
      4'h9: ref_decode = ACM_REF_MCLK_SLOW;
      default: ref_decode = ACM_REF_NA;
    endcase
  endfunction

  function automatic logic is_mclk_ref(input acm_ref_t r);
    is_mclk_ref = (r == ACM_REF_MCLK) || (r == ACM_REF_MCLK_SLOW);
  endfunction

  function automatic logic fs_code_ok(input acm_ref_t r, input logic [3:0] fs);
    if (is_mclk_ref(r)) begin
      case (fs)
        4'h8, 4'h9, 4'hC, 4'hD: fs_code_ok = 1'b0;
        default: fs_code_ok = 1'b1;
      endcase
    end else begin
      fs_code_ok = (fs[3:2] != 2'b11);
    end
  endfunction

  // generator tick period for 512fs; bit/frame reference uses the top of its range
  function automatic logic [`ACM_TICK_W-1:0] tick_period(input acm_ref_t r,
                                                         input logic [3:0] fs);
    logic [`ACM_TICK_W-1:0] p;
    p = `ACM_TICK_W'(`ACM_TICK_CYC(48000));
    if (is_mclk_ref(r)) begin
      case (fs)
        4'h0: p = `ACM_TICK_W'(`ACM_TICK_CYC(8000));
        4'h1: p = `ACM_TICK_W'(`ACM_TICK_CYC(12000));
        4'h2: p = `ACM_TICK_W'(`ACM_TICK_CYC(16000));
        4'h3: p = `ACM_TICK_W'(`ACM_TICK_CYC(24000));
        4'h4: p = `ACM_TICK_W'(`ACM_TICK_CYC(7350));
        4'h5: p = `ACM_TICK_W'(`ACM_TICK_CYC(11025));
        4'h6: p = `ACM_TICK_W'(`ACM_TICK_CYC(14700));
        4'h7: p = `ACM_TICK_W'(`ACM_TICK_CYC(22050));
        4'hA: p = `ACM_TICK_W'(`ACM_TICK_CYC(32000));
        4'hE: p = `ACM_TICK_W'(`ACM_TICK_CYC(29400));
        4'hF: p = `ACM_TICK_W'(`ACM_TICK_CYC(44100));
        default: p = `ACM_TICK_W'(`ACM_TICK_CYC(48000));
      endcase
    end else begin
      case (fs[3:2])
        2'b00: p = `ACM_TICK_W'(`ACM_TICK_CYC(12000));
        2'b01: p = `ACM_TICK_W'(`ACM_TICK_CYC(24000));
        default: p = `ACM_TICK_W'(`ACM_TICK_CYC(48000));
      endcase
    end
    tick_period = p;
  endfunction

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] v;
    v = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        v[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    apply_strb = v;
  endfunction

  acm_ctrl_t ctrl_r;
  acm_state_t state_r;
  acm_status_t status;
  acm_ref_t ref_sel;
  logic ref_ok, fs_ok, cfg_ok, cfg_changed;
  logic [7:0] cfg_key, cfg_key_r;
  logic [`ACM_LOCK_W-1:0] lock_cnt_r, lock_target;
  logic [`ACM_GEN_W-1:0] gen_r;
  logic [3:0] scr_r;
  logic pll_power_d_r, mclk_prev_r, half_r, int_tick, ext_tick, gen_tick, gen_clr;
  logic gen_run, mclk_sel, bck_sel, lock_ok, dac_active_r;
  logic aw_hold_r, w_hold_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  assign ref_sel = ref_decode(ctrl_r.pll_ref_select);
  assign ref_ok = (ref_sel != ACM_REF_NA);
  assign fs_ok = fs_code_ok(ref_sel, ctrl_r.fs_select);
  assign cfg_ok = ref_ok && fs_ok;
  // a bit/frame reference ignores the low fs bits, so they do not force a relock
  assign cfg_key = {ctrl_r.pll_ref_select, ctrl_r.fs_select[3:2],
                    is_mclk_ref(ref_sel) ? ctrl_r.fs_select[1:0] : 2'b00};
  assign cfg_changed = (cfg_key != cfg_key_r);

  always_comb begin
    case (ref_sel)
      ACM_REF_FRAME: lock_target = `ACM_LOCK_W'(LOCK_FRAME_CYC);
      ACM_REF_BIT: lock_target = `ACM_LOCK_W'(LOCK_BIT_CYC);
      ACM_REF_MCLK_SLOW: lock_target = `ACM_LOCK_W'(LOCK_MCLK_SLOW_CYC);
      default: lock_target = `ACM_LOCK_W'(LOCK_MCLK_CYC);
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_key_r <= '0;
      pll_power_d_r <= 1'b0;
    end else begin
      cfg_key_r <= cfg_key;
      pll_power_d_r <= ctrl_r.pll_power;
    end
  end

  // lock model: a pll reaches lock after its worst-case lock time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ACM_ST_BYPASS;
      lock_cnt_r <= '0;
    end else begin
      case (state_r)
        ACM_ST_BYPASS: begin
          lock_cnt_r <= '0;
          if (ctrl_r.pll_power) begin
            state_r <= ACM_ST_PWRUP;
          end
        end
        ACM_ST_PWRUP, ACM_ST_RELOCK: begin
          if (!ctrl_r.pll_power) begin
            state_r <= ACM_ST_BYPASS;
          end else if (!cfg_ok || cfg_changed) begin
            lock_cnt_r <= '0;
          end else if (lock_cnt_r >= lock_target - `ACM_LOCK_W'(1)) begin
            state_r <= ACM_ST_SETTLE;
          end else begin
            lock_cnt_r <= lock_cnt_r + `ACM_LOCK_W'(1);
          end
        end
        ACM_ST_SETTLE, ACM_ST_LOCKED: begin
          lock_cnt_r <= '0;
          if (!ctrl_r.pll_power) begin
            state_r <= ACM_ST_BYPASS;
          end else if (!cfg_ok || cfg_changed) begin
            state_r <= ACM_ST_RELOCK;
          end else if (state_r == ACM_ST_SETTLE && gen_tick && (&gen_r)) begin
            state_r <= ACM_ST_LOCKED;
          end
        end
        default: state_r <= ACM_ST_BYPASS;
      endcase
    end
  end

  acm_tick_div #(
    .W(`ACM_TICK_W)
  ) u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(ctrl_r.pll_power && cfg_ok),
    .clr(cfg_changed),
    .period(tick_period(ref_sel, ctrl_r.fs_select)),
    .tick_r(int_tick)
  );

  // external mode: master_clk_in edges become 512fs ticks per the ratio code
  always_comb begin
    case (ctrl_r.fs_select[1:0])
      2'b00: ext_tick = (master_clk_in != mclk_prev_r);
      2'b01: ext_tick = master_clk_in && !mclk_prev_r && half_r;
      default: ext_tick = master_clk_in && !mclk_prev_r;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mclk_prev_r <= 1'b0;
      half_r <= 1'b0;
    end else begin
      mclk_prev_r <= master_clk_in;
      if (master_clk_in && !mclk_prev_r) begin
        half_r <= !half_r;
      end
    end
  end

  assign gen_run = ctrl_r.pll_power ? cfg_ok : 1'b1;
  assign gen_tick = gen_run && (ctrl_r.pll_power ? int_tick : ext_tick);
  // restarting on a pll_power change keeps the switchover free of runt pulses
  assign gen_clr = !gen_run || (ctrl_r.pll_power != pll_power_d_r);

  always_ff @(posedge aclk) begin
    if (!aresetn || gen_clr) begin
      gen_r <= '0;
    end else if (gen_tick) begin
      gen_r <= gen_r + `ACM_GEN_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scr_r <= 4'h1;
    end else begin
      scr_r <= {scr_r[2:0], scr_r[3] ^ scr_r[2]};
    end
  end

  always_comb begin
    case (ctrl_r.mclk_out_div)
      2'b00: mclk_sel = gen_r[`ACM_TAP_256FS];
      2'b01: mclk_sel = gen_r[`ACM_TAP_128FS];
      2'b10: mclk_sel = gen_r[`ACM_TAP_64FS];
      default: mclk_sel = gen_r[`ACM_TAP_32FS];
    endcase
  end
  assign bck_sel = ctrl_r.bitclk_out_rate ? gen_r[`ACM_TAP_64FS] : gen_r[`ACM_TAP_32FS];
  assign lock_ok = (state_r == ACM_ST_SETTLE) || (state_r == ACM_ST_LOCKED);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mclk_out <= 1'b0;
    end else if (!ctrl_r.mclk_out_enable) begin
      mclk_out <= 1'b0;
    end else if (!ctrl_r.pll_power) begin
      mclk_out <= mclk_sel;
    end else if (!cfg_ok || (!ctrl_r.master_slave_select && !is_mclk_ref(ref_sel))) begin
      mclk_out <= 1'b0;
    end else if (!lock_ok) begin
      mclk_out <= mclk_sel ^ scr_r[`ACM_SCRAMBLE_BIT];
    end else begin
      mclk_out <= mclk_sel;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl_r.master_slave_select) begin
      bit_clock_oe <= 1'b0;
      frame_clock_oe <= 1'b0;
      bit_clock_out <= 1'b0;
      frame_clock_out <= 1'b0;
    end else begin
      bit_clock_oe <= 1'b1;
      frame_clock_oe <= 1'b1;
      if (!ctrl_r.pll_power) begin
        bit_clock_out <= bck_sel;
        frame_clock_out <= gen_r[`ACM_TAP_1FS];
      end else if (state_r == ACM_ST_PWRUP || state_r == ACM_ST_BYPASS || gen_clr) begin
        bit_clock_out <= 1'b0;
        frame_clock_out <= 1'b0;
      end else begin
        bit_clock_out <= bck_sel;
        frame_clock_out <= gen_r[`ACM_TAP_1FS];
      end
    end
  end

  // dac stays down until master_clk_in shows an edge after dac_power is set
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl_r.dac_power) begin
      dac_active_r <= 1'b0;
    end else if (master_clk_in != mclk_prev_r) begin
      dac_active_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_run <= 1'b0;
      hp_path_en <= 1'b0;
      spk_path_en <= 1'b0;
    end else begin
      dac_run <= dac_active_r;
      hp_path_en <= ctrl_r.hp_dac_path;
      spk_path_en <= ctrl_r.spk_dac_path;
    end
  end

  always_comb begin
    status = '0;
    status.state = state_r;
    status.locked = (state_r == ACM_ST_LOCKED);
    status.clocks_valid = ctrl_r.pll_power ? (state_r == ACM_ST_LOCKED) : 1'b1;
    status.dac_active = dac_active_r;
    status.ref_ok = ref_ok;
    status.fs_ok = fs_ok;
    // software should clear both dac paths while this reads one
    status.mute_advised = ctrl_r.pll_power && (state_r != ACM_ST_LOCKED) &&
                          (ctrl_r.hp_dac_path || ctrl_r.spk_dac_path);
  end

  // write channel: address and data taken in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= acm_ctrl_t'(`ACM_CTRL_RST);
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ACM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_hold_r && w_hold_r && !s_axi_bvalid) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_r[ADDR_W-1:2] == `ACM_OFF_CTRL >> 2) begin
          ctrl_r <= acm_ctrl_t'(apply_strb(ctrl_r, wdata_r, wstrb_r) & `ACM_CTRL_MASK);
          s_axi_bresp <= `ACM_RESP_OKAY;
        end else begin
          s_axi_bresp <= `ACM_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `ACM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr[ADDR_W-1:2] == `ACM_OFF_CTRL >> 2) begin
        s_axi_rdata <= ctrl_r;
        s_axi_rresp <= `ACM_RESP_OKAY;
      end else if (s_axi_araddr[ADDR_W-1:2] == `ACM_OFF_STATUS >> 2) begin
        s_axi_rdata <= status;
        s_axi_rresp <= `ACM_RESP_OKAY;
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= `ACM_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// [test/acm_host_model.sv]
// behavioural audio host: supplies master_clk_in and slave bit/frame clocks
// assumes aclk is the bench clock; clocks stand still while run is low
`timescale 1ns/1ps
module acm_host_model (
  input wire logic aclk, // bench clock
  input wire logic run, // host keeps its clocks running
  output logic master_clk_in = 1'b0, // master clock, a quarter of aclk
  output logic bck = 1'b0, // slave bit clock
  output logic frame_clock = 1'b0 // slave frame clock
);
  logic [8:0] cnt_r = 9'h000;
  // clocks stop with run, as a host without clocks would
  always @(posedge aclk) begin
    if (run) begin
      cnt_r <= cnt_r + 9'h001;
      if (cnt_r[0]) master_clk_in <= ~master_clk_in;
      bck <= cnt_r[4];
      frame_clock <= cnt_r[8];
    end
  end
endmodule

// [test/acm_top_asserts.sv]
// port checker of acm_top
// assumes it is bound into every acm_top instance
`timescale 1ns/1ps
module acm_top_chk #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk, // bus clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic master_clk_in, // master clock pin
  input wire logic bit_clock_oe, // bit clock enable
  input wire logic frame_clock_oe, // frame clock enable
  input wire logic mclk_out, // master clock output
  input wire logic dac_run, // dac awake
  input wire logic hp_path_en, // headphone path
  input wire logic spk_path_en // speaker path
);
  logic [31:0] m_r, wd_r, msk;
  logic [3:0] ws_r, since_r;
  logic [2:0] bv_r;
  logic aw0_r, mck_r, calm;
  assign msk = {{8{ws_r[3]}}, {8{ws_r[2]}}, {8{ws_r[1]}}, {8{ws_r[0]}}};
  // calm: outputs have settled after the last write
  assign calm = !s_axi_bvalid && bv_r == 3'b000;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      m_r <= 32'h0000_0000;
      bv_r <= 3'b000;
    end else begin
      bv_r <= {bv_r[1:0], s_axi_bvalid};
      if (s_axi_awvalid && s_axi_awready) aw0_r <= s_axi_awaddr[ADDR_W-1:2] == '0;
      if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata;
      if (s_axi_wvalid && s_axi_wready) ws_r <= s_axi_wstrb;
      if (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'b00 && aw0_r) begin
        m_r <= (m_r & ~msk) | (wd_r & msk);
      end
    end
  end
  always_ff @(posedge aclk) begin
    mck_r <= master_clk_in;
    if (master_clk_in != mck_r) since_r <= 4'h0;
    else if (since_r != 4'hF) since_r <= since_r + 4'h1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  rst_quiet_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
    && !bit_clock_oe && !mclk_out && !dac_run && s_axi_awready) else $error("reset outputs");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer dropped");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  mclk_off_a: assert property (calm && !m_r[12] |-> !mclk_out)
    else $error("mclk_out while disabled");
  oe_mode_a: assert property (calm |-> bit_clock_oe == m_r[1]
    && frame_clock_oe == m_r[1]) else $error("pin drive vs mode");
  path_copy_a: assert property (calm |-> hp_path_en == m_r[17] && spk_path_en == m_r[18])
    else $error("dac path outputs wrong");
  dac_off_a: assert property (calm && !m_r[16] |-> !dac_run)
    else $error("dac runs while off");
  dac_wake_a: assert property ($rose(dac_run) |-> since_r <= 4'h6)
    else $error("dac woke without mclk");
endmodule
bind acm_top acm_top_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// [test/testbench.sv]
// bench of acm_top: AXI4-Lite master and host clock model
// assumes short lock counts; reads are checked from a note queue
`timescale 1ns/1ps
`include "acm_defs.svh"
module testbench import acm_pkg::*;;
  logic aclk = 1'b0, aresetn = 1'b0, mclk_run = 1'b0, host_bck, host_frame_clock, rok, fok, pf, pb, pm;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, lfsr = 32'h6E3DDD46, got;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic master_clk_in, bit_clock_in, frame_clock_in, bit_clock_out, bit_clock_oe;
  logic frame_clock_out, frame_clock_oe, mclk_out, dac_run, hp_path_en, spk_path_en;
  logic [65:0] notes[$], nt;
  int num_errors = 0, n_compared = 0, nb, nm;
  assign bit_clock_in = bit_clock_oe ? bit_clock_out : host_bck;
  assign frame_clock_in = frame_clock_oe ? frame_clock_out : host_frame_clock;
  acm_top #(.LOCK_FRAME_CYC(50), .LOCK_BIT_CYC(20), .LOCK_MCLK_CYC(30),
    .LOCK_MCLK_SLOW_CYC(60)) dut (.*);
  acm_host_model host (.aclk, .run(mclk_run), .master_clk_in, .bck(host_bck), .frame_clock(host_frame_clock));
  initial forever #4 aclk = ~aclk;
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (exp !== seen) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int n = 0; n < 64 && !(s_axi_bvalid === 1'b1 && s_axi_bready); n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1 && !s_axi_bready) s_axi_bready <= 1'b1;
    end
    chk("bresp", er, s_axi_bresp);
    s_axi_bready <= 1'b0;
  endtask
  // note queued first; the monitor pops it at the handshake
  task automatic rd(input logic [11:0] a, input logic [31:0] e, m, input logic [1:0] er);
    notes.push_back({er, m, e});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 64 && !(s_axi_rvalid === 1'b1 && s_axi_rready); n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1 && !s_axi_rready) s_axi_rready <= 1'b1;
    end
    got = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
      nt = notes.size() > 0 ? notes.pop_front() : {2'b11, 64'h0};
      chk("rdata", nt[31:0] & nt[63:32], s_axi_rdata & nt[63:32]);
      chk("rresp", nt[65:64], s_axi_rresp);
    end
  end
  // bit clock and mclk_out rising edges in one frame
  task automatic meas;
    int k = 0;
    nb = 0;
    nm = 0;
    pf = 1'b1;
    for (int n = 0; n < 9000 && k < 2; n++) begin
      @(posedge aclk);
      if (frame_clock_out === 1'b1 && !pf) k++;
      if (k == 1) nb += bit_clock_out & !pb;
      if (k == 1) nm += mclk_out & !pm;
      pf = frame_clock_out;
      pb = bit_clock_out;
      pm = mclk_out;
    end
  endtask
  initial begin
    repeat (90000) @(posedge aclk);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h000, 32'h0, 32'hFFFFFFFF, 2'b00);
    rd(12'h004, 32'h0, 32'h7, 2'b00);
    rd(12'h008, 32'h0, 32'hFFFFFFFF, 2'b10);
    wr(12'h004, 32'h1, 2'b10);
    lfsr = nxt(lfsr);
    wr(12'h000, lfsr, 2'b00);
    s_axi_wstrb <= 4'h4;
    wr(12'h000, 32'hFFFFFFFF, 2'b00);
    s_axi_wstrb <= 4'hF;
    rd(12'h000, (lfsr | 32'h00FF0000) & `ACM_CTRL_MASK, 32'hFFFFFFFF, 2'b00);
    for (int r = 0; r < 16; r++) for (int f = 0; f < 16; f++) begin
      wr(12'h000, 32'h1 | (r << 4) | (f << 8), 2'b00);
      rok = r inside {0, 2, 3, 4, 5, 6, 7, 9, 12, 13};
      fok = r > 3 ? f inside {[0:7], 10, 11, 14, 15} : f[3:2] != 2'b11;
      rd(12'h004, {fok, rok, 6'h0}, {rok, 1'b1, 6'h0}, 2'b00);
    end
    wr(12'h000, 32'h10000, 2'b00);
    repeat (20) @(posedge aclk);
    chk("dac_run", 32'h0, dac_run);
    mclk_run <= 1'b1;
    repeat (20) @(posedge aclk);
    chk("dac_run", 32'h1, dac_run);
    for (int d = 0; d < 4; d++) begin
      wr(12'h000, 32'h11002 | ({d[0], d[1:0]} << 13), 2'b00);
      meas();
      chk("bits per frame", 32 << d[0], nb);
      chk("mclk per frame", 256 >> d, nm);
    end
    wr(12'h000, 32'h00009B43, 2'b00);
    rd(12'h004, 32'h1, 32'h7, 2'b00);
    chk("bit clock low", 32'h0, {bit_clock_out, frame_clock_out});
    got = 32'h0;
    for (int n = 0; n < 1000 && !got[3]; n++) rd(12'h004, 32'h0, 32'h0, 2'b00);
    rd(12'h004, 32'h1B, 32'h1F, 2'b00);
    meas();
    chk("pll bits per frame", 32'd64, nb);
    chk("pll mclk per frame", 32'd256, nm);
    mclk_run <= 1'b0;
    wr(12'h000, 32'h00000B42, 2'b00);
    repeat (8) @(posedge aclk);
    chk("clocks low", 32'h0, {bit_clock_out, frame_clock_out});
    wr(12'h000, 32'h00001011, 2'b00);
    repeat (30) @(posedge aclk);
    chk("bad ref clocks low", 32'h0, {mclk_out, bit_clock_out});
    tally_and_finish();
  end
endmodule
